// *** common/rx_flags_map.svh ***
/*
 Register offsets, bit masks and reset values of the receive-mode
 status and interrupt flag block. Assumes a byte-addressed register port.
*/
`ifndef RX_FLAGS_MAP_SVH
`define RX_FLAGS_MAP_SVH

`define RX_AW 16
`define RX_CLR_OFF 16'h0028
`define RX_STAT_OFF 16'h002C
`define RX_LATCH_OFF 16'h0030
`define RX_EN_OFF 16'h0034

`define RX_M_AUX_ERR 32'h8000_0000
`define RX_M_AUX_RCVD 32'h4000_0000
`define RX_M_AUX_SENT 32'h2000_0000
`define RX_M_EXT_PROFILE 32'h1000_0000
`define RX_M_RECT_PWR 32'h0400_0000
`define RX_M_NO_HOST_TMO 32'h0200_0000
`define RX_M_PROFILE_CHK 32'h0040_0000
`define RX_M_PWR_LOSS 32'h0020_0000
`define RX_M_CUR_NEAR 32'h0010_0000
`define RX_M_RENEG_FAIL 32'h0008_0000
`define RX_M_RENEG_OK 32'h0004_0000
`define RX_M_OOB_OK 32'h0002_0000
`define RX_M_HOST_5V_OFF 32'h0001_0000
`define RX_M_FAST_FAIL 32'h0000_8000
`define RX_M_SLEEP 32'h0000_4000
`define RX_M_ID_PASS 32'h0000_2000
`define RX_M_ID_FAIL 32'h0000_1000
`define RX_M_BC_OK 32'h0000_0800
`define RX_M_BC_FAIL 32'h0000_0400
`define RX_M_TX_PASS 32'h0000_0200
`define RX_M_TX_FAIL 32'h0000_0100
`define RX_M_REG_OFF 32'h0000_0080
`define RX_M_REG_ON 32'h0000_0040
`define RX_M_MODE_CHG 32'h0000_0020
`define RX_M_VENDOR_PKT 32'h0000_0010
`define RX_M_FAST_OK 32'h0000_0008
`define RX_M_OVER_TEMP 32'h0000_0004
`define RX_M_OVER_VOLT 32'h0000_0002
`define RX_M_OVER_CUR 32'h0000_0001

`define RX_NO_HOST_BIT 25
`define RX_RECT_BIT 26
`define RX_ZERO 32'h0000_0000
`define RX_EN_FIXED (`RX_M_RENEG_FAIL | `RX_M_RENEG_OK)

`endif

// *** common/rx_flags_pkg.sv ***
/*
 Types shared by the receive-mode flag block and its bench.
 Assumes rx_flags_map.svh is on the include path.
*/
`default_nettype none
`include "rx_flags_map.svh"

package rx_flags_pkg;

    typedef struct packed {
        logic [`RX_AW-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

`default_nettype wire

// *** logic/rx_status_interrupt_flags.sv ***
/*
 Receive-mode condition status word, latched event word, clear word and
 enable word, with one level interrupt toward the host processor.
 Assumes condition levels synchronous to sys_clk and a register master
 that never issues read and write strobes together.
*/
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

`include "rx_flags_map.svh"

// How it works
// R1 - Status word reads live conditions, reserved zero
// R2 - Event word bits reset zero, set on event
// R3 - Power-present bit 26 set when power applied
// R4 - Power-present clears on reset or power loss
// R5 - Power-present events only on rising edge
// R6 - Bit 25 host timeout, host writable both words
// R7 - Bits 31..29 aux transport error, received, sent
// R8 - Bit 28 extended profile, bit 22 check
// R9 - Bit 21 power loss detected
// R10 - Bit 20 output current near limit
// R11 - Bits 19/18 renegotiation fail and success
// R12 - Bit 17 out-of-band exchange succeeded
// R13 - Bit 16 host 5 V path disabled
// R14 - Bit 15 fast charge fail, bit 3 success
// R15 - Bit 14 reads one while asleep
// R16 - Bits 13/12 identity authentication pass, fail
// R17 - Bits 11/10 back-channel accepted, failed
// R18 - Bits 9/8 transmitter authentication pass, fail
// R19 - Bits 7/6 output regulator disabled, enabled
// R20 - Bit 5 operating mode changed
// R21 - Bit 4 vendor packet received
// R22 - Bits 2..0 over-temperature, voltage, current
// R23 - Write one to clear word, self-clears
// R24 - Enable word gates sources, defaults one
// R25 - Interrupt while any enabled latched bit
module rx_status_interrupt_flags
    import rx_flags_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire reg_req_t req,
    input wire logic [31:0] cond_lvl,
    output logic [31:0] rdata_q,
    output logic irq_q
);

    logic [31:0] def_mask;
    logic [31:0] cond_m;
    logic [31:0] rise;
    logic [31:0] stat_q;
    logic [31:0] stat_d;
    logic [31:0] cond_prev_q;
    logic [31:0] latch_q;
    logic [31:0] latch_d;
    logic [31:0] latch_keep;
    logic [31:0] clr_bits;
    logic [31:0] en_q;
    logic [31:0] en_d;
    logic [31:0] en_wmask;
    logic [31:0] rd_mux;
    logic [31:0] rdata_d;
    logic [31:0] b25;
    logic stat25_d;
    logic wr_clr;
    logic wr_stat;
    logic wr_latch;
    logic wr_en;
    logic sel_clr;
    logic sel_stat;
    logic sel_latch;
    logic sel_en;
    logic irq_d;

    // Every defined source; bits 27 and 24..23 stay out
    assign def_mask = `RX_M_AUX_ERR  // R7
        | `RX_M_AUX_RCVD  // R7
        | `RX_M_AUX_SENT  // R7
        | `RX_M_EXT_PROFILE  // R8
        | `RX_M_RECT_PWR  // R3
        | `RX_M_NO_HOST_TMO  // R6
        | `RX_M_PROFILE_CHK  // R8
        | `RX_M_PWR_LOSS  // R9
        | `RX_M_CUR_NEAR  // R10
        | `RX_M_RENEG_FAIL  // R11
        | `RX_M_RENEG_OK  // R11
        | `RX_M_OOB_OK  // R12
        | `RX_M_HOST_5V_OFF  // R13
        | `RX_M_FAST_FAIL  // R14
        | `RX_M_SLEEP  // R15
        | `RX_M_ID_PASS  // R16
        | `RX_M_ID_FAIL  // R16
        | `RX_M_BC_OK  // R17
        | `RX_M_BC_FAIL  // R17
        | `RX_M_TX_PASS  // R18
        | `RX_M_TX_FAIL  // R18
        | `RX_M_REG_OFF  // R19
        | `RX_M_REG_ON  // R19
        | `RX_M_MODE_CHG  // R20
        | `RX_M_VENDOR_PKT  // R21
        | `RX_M_FAST_OK  // R14
        | `RX_M_OVER_TEMP  // R22
        | `RX_M_OVER_VOLT  // R22
        | `RX_M_OVER_CUR;  // R22

    assign b25 = `RX_M_NO_HOST_TMO;

    assign cond_m = cond_lvl & def_mask;  // R1

    // Falling conditions never raise an event
    assign rise = cond_m & ~cond_prev_q;  // R5

    // Address decode
    assign sel_clr = (req.addr == `RX_CLR_OFF);
    assign sel_stat = (req.addr == `RX_STAT_OFF);
    assign sel_latch = (req.addr == `RX_LATCH_OFF);
    assign sel_en = (req.addr == `RX_EN_OFF);

    assign wr_clr = req.wr && sel_clr;
    assign wr_stat = req.wr && sel_stat;
    assign wr_latch = req.wr && sel_latch;
    assign wr_en = req.wr && sel_en;

    // Status word: live levels, except the host-writable timeout bit
    assign stat25_d = cond_m[`RX_NO_HOST_BIT]
        | (wr_stat ? req.wdata[`RX_NO_HOST_BIT]
                   : stat_q[`RX_NO_HOST_BIT]);  // R6
    assign stat_d = (cond_m & ~b25)
        | (stat25_d ? b25 : `RX_ZERO);  // R4

    // Event word: host write of bit 25, then clears, then new events
    assign latch_keep = wr_latch
        ? ((latch_q & ~b25) | (req.wdata & b25))
        : latch_q;  // R6
    assign clr_bits = wr_clr ? req.wdata : `RX_ZERO;  // R23
    // A new event in the clearing cycle survives the clear
    assign latch_d = ((latch_keep & ~clr_bits) | rise)
        & def_mask;  // R2

    // Renegotiation enables are read-only and stay set
    assign en_wmask = def_mask & ~`RX_EN_FIXED;
    assign en_d = wr_en
        ? ((req.wdata & en_wmask) | (en_q & ~en_wmask))
        : en_q;  // R24

    assign irq_d = |(latch_q & en_q);  // R25

    // Clear word always reads zero: it self-clears at once
    assign rd_mux = sel_stat ? stat_q
        : sel_latch ? latch_q
        : sel_en ? en_q
        : `RX_ZERO;  // R23
    assign rdata_d = req.rd ? rd_mux : `RX_ZERO;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cond_prev_q <= `RX_ZERO;
            stat_q <= `RX_ZERO;
        end else begin
            cond_prev_q <= cond_m;
            stat_q <= stat_d;  // R3
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            latch_q <= `RX_ZERO;  // R2
        end else begin
            latch_q <= latch_d;
        end
    end

    // Enable reset value equals the defined-bit set
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_q <= `RX_M_AUX_ERR | `RX_M_AUX_RCVD
                | `RX_M_AUX_SENT | `RX_M_EXT_PROFILE
                | `RX_M_RECT_PWR | `RX_M_NO_HOST_TMO
                | `RX_M_PROFILE_CHK | `RX_M_PWR_LOSS
                | `RX_M_CUR_NEAR | `RX_M_RENEG_FAIL
                | `RX_M_RENEG_OK | `RX_M_OOB_OK
                | `RX_M_HOST_5V_OFF | `RX_M_FAST_FAIL
                | `RX_M_SLEEP | `RX_M_ID_PASS
                | `RX_M_ID_FAIL | `RX_M_BC_OK
                | `RX_M_BC_FAIL | `RX_M_TX_PASS
                | `RX_M_TX_FAIL | `RX_M_REG_OFF
                | `RX_M_REG_ON | `RX_M_MODE_CHG
                | `RX_M_VENDOR_PKT | `RX_M_FAST_OK
                | `RX_M_OVER_TEMP | `RX_M_OVER_VOLT
                | `RX_M_OVER_CUR;  // R24
        end else begin
            en_q <= en_d;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
            rdata_q <= `RX_ZERO;
        end else begin
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    a_rect_rise_latch: assert property (  // R3
        @(posedge sys_clk) disable iff (!arst_n)
        cond_m[`RX_RECT_BIT] && !cond_prev_q[`RX_RECT_BIT]
        |=> latch_q[`RX_RECT_BIT] && stat_q[`RX_RECT_BIT])
        else $error("power-present rise not latched");

    a_rect_fall_quiet: assert property (  // R5
        @(posedge sys_clk) disable iff (!arst_n)
        !latch_q[`RX_RECT_BIT] && !cond_m[`RX_RECT_BIT]
        |=> !latch_q[`RX_RECT_BIT])
        else $error("event raised without a rising edge");

    a_rect_clears: assert property (  // R4
        @(posedge sys_clk) disable iff (!arst_n)
        $fell(cond_lvl[`RX_RECT_BIT])
        |=> !stat_q[`RX_RECT_BIT])
        else $error("power-present status did not clear");

    a_reserved_zero: assert property (  // R1
        @(posedge sys_clk) disable iff (!arst_n)
        ((stat_q | latch_q | en_q) & ~def_mask) == `RX_ZERO)
        else $error("reserved bit set");

    a_set_wins: assert property (  // R2
        @(posedge sys_clk) disable iff (!arst_n)
        rise != `RX_ZERO
        |=> (latch_q & $past(rise)) == $past(rise))
        else $error("event lost");

    a_clear_w1c: assert property (  // R23
        @(posedge sys_clk) disable iff (!arst_n)
        wr_clr
        |=> (latch_q & $past(req.wdata & ~rise)) == `RX_ZERO)
        else $error("write-one clear failed");

    a_irq_gate: assert property (  // R25
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 irq_q == $past(|(latch_q & en_q)))
        else $error("interrupt does not track enabled events");

    a_en_fixed: assert property (  // R24
        @(posedge sys_clk) disable iff (!arst_n)
        (en_q & `RX_EN_FIXED) == `RX_EN_FIXED)
        else $error("read-only enable bits changed");

    a_stat_read: assert property (  // R1
        @(posedge sys_clk) disable iff (!arst_n)
        req.rd && sel_stat |=> rdata_q == $past(stat_q))
        else $error("status read data wrong");

    a_timeout_write: assert property (  // R6
        @(posedge sys_clk) disable iff (!arst_n)
        wr_stat |=> stat_q[`RX_NO_HOST_BIT] ==
            $past(req.wdata[`RX_NO_HOST_BIT] | cond_m[`RX_NO_HOST_BIT]))
        else $error("timeout status write wrong");

    // Plain status bits copy their levels one edge late; only the timeout bit is sticky
    a_aux_track: assert property (  // R7
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & (`RX_M_AUX_ERR | `RX_M_AUX_RCVD | `RX_M_AUX_SENT)) == `RX_ZERO)
        else $error("transport status wrong");

    a_profile_track: assert property (  // R8
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & (`RX_M_EXT_PROFILE | `RX_M_PROFILE_CHK)) == `RX_ZERO)
        else $error("profile status wrong");

    a_loss_track: assert property (  // R9
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & `RX_M_PWR_LOSS) == `RX_ZERO)
        else $error("power loss status wrong");

    a_current_track: assert property (  // R10
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & `RX_M_CUR_NEAR) == `RX_ZERO)
        else $error("current limit status wrong");

    a_reneg_track: assert property (  // R11
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & (`RX_M_RENEG_FAIL | `RX_M_RENEG_OK)) == `RX_ZERO)
        else $error("renegotiation status wrong");

    a_oob_track: assert property (  // R12
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & `RX_M_OOB_OK) == `RX_ZERO)
        else $error("out-of-band status wrong");

    a_host_5v_track: assert property (  // R13
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & `RX_M_HOST_5V_OFF) == `RX_ZERO)
        else $error("host supply status wrong");

    a_fast_track: assert property (  // R14
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & (`RX_M_FAST_FAIL | `RX_M_FAST_OK)) == `RX_ZERO)
        else $error("fast charge status wrong");

    a_sleep_track: assert property (  // R15
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & `RX_M_SLEEP) == `RX_ZERO)
        else $error("sleep status wrong");

    a_id_auth_track: assert property (  // R16
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & (`RX_M_ID_PASS | `RX_M_ID_FAIL)) == `RX_ZERO)
        else $error("identity status wrong");

    a_back_channel_track: assert property (  // R17
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & (`RX_M_BC_OK | `RX_M_BC_FAIL)) == `RX_ZERO)
        else $error("back-channel status wrong");

    a_tx_auth_track: assert property (  // R18
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & (`RX_M_TX_PASS | `RX_M_TX_FAIL)) == `RX_ZERO)
        else $error("transmitter auth status wrong");

    a_regulator_track: assert property (  // R19
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & (`RX_M_REG_OFF | `RX_M_REG_ON)) == `RX_ZERO)
        else $error("regulator status wrong");

    a_mode_track: assert property (  // R20
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & `RX_M_MODE_CHG) == `RX_ZERO)
        else $error("mode change status wrong");

    a_vendor_track: assert property (  // R21
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & `RX_M_VENDOR_PKT) == `RX_ZERO)
        else $error("vendor packet status wrong");

    a_fault_track: assert property (  // R22
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 ((stat_q ^ $past(cond_lvl))
            & (`RX_M_OVER_TEMP | `RX_M_OVER_VOLT | `RX_M_OVER_CUR)) == `RX_ZERO)
        else $error("fault status wrong");

    c_rect_event: cover property (
        @(posedge sys_clk) disable iff (!arst_n)
        rise[`RX_RECT_BIT] ##1 irq_q);

    c_clear_event: cover property (
        @(posedge sys_clk) disable iff (!arst_n)
        latch_q != `RX_ZERO ##1 wr_clr ##1 latch_q == `RX_ZERO);

    c_masked_event: cover property (
        @(posedge sys_clk) disable iff (!arst_n)
        latch_q != `RX_ZERO && (latch_q & en_q) == `RX_ZERO);

    c_set_over_clear: cover property (
        @(posedge sys_clk) disable iff (!arst_n)
        wr_clr && (rise & req.wdata) != `RX_ZERO);

    c_timeout_write: cover property (
        @(posedge sys_clk) disable iff (!arst_n)
        wr_latch && req.wdata[`RX_NO_HOST_BIT] ##1 latch_q[`RX_NO_HOST_BIT]);

endmodule

`default_nettype wire

// *** testbench/rx_host_model.sv ***
/*
 Host register master model for the receive-mode flag block.
 Assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/10ps
`default_nettype none
module rx_host_model
    import rx_flags_pkg::*;
(
    input wire logic sys_clk,
    output var reg_req_t req,
    input wire logic [31:0] rdata_q
);
    initial req = '0;

    // Strobe held through the taking edge, dropped right after it
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req <= '0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req <= '0;
        // Read data stand only in this one cycle
        #1 d = rdata_q;
    endtask
endmodule
`default_nettype wire

// *** testbench/rx_status_interrupt_flags_tb_top.sv ***
/*
 Self-checking bench of the receive-mode flag block.
 Assumes rx_flags_map.svh on the include path and a 50 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rx_flags_map.svh"
module rx_status_interrupt_flags_tb_top
    import rx_flags_pkg::*;
;
    localparam logic [31:0] DEFN = 32'hF67F_FFFF;
    logic sys_clk;
    logic arst_n;
    logic [31:0] cond_lvl;
    logic [31:0] rdata_q;
    logic [31:0] v;
    logic irq_q;
    reg_req_t req;
    int bad_count;
    int tests_run;

    rx_status_interrupt_flags u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .req(req),
        .cond_lvl(cond_lvl), .rdata_q(rdata_q), .irq_q(irq_q));
    rx_host_model u_host (.sys_clk(sys_clk), .req(req), .rdata_q(rdata_q));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rchk(input string n, input logic [15:0] a, input logic [31:0] e);
        u_host.rd(a, v);
        chk(n, v, e);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check_reset();
        rchk("enable", `RX_EN_OFF, DEFN);
        rchk("latch", `RX_LATCH_OFF, `RX_ZERO);
        rchk("status", `RX_STAT_OFF, `RX_ZERO);
        rchk("clear word", `RX_CLR_OFF, `RX_ZERO);
        rchk("unmapped", 16'h0038, `RX_ZERO);
        chk("irq", {31'h0, irq_q}, 32'h0);
    endtask

    // Every bit rises, is read, cleared while still high, then falls
    task automatic sweep();
        logic [31:0] m;
        for (int i = 0; i < 32; i++) begin
            m = 32'h1 << i;
            @(posedge sys_clk) cond_lvl <= m;
            repeat (3) @(posedge sys_clk);
            rchk("status bit", `RX_STAT_OFF, m & DEFN);
            rchk("latch bit", `RX_LATCH_OFF, m & DEFN);
            chk("irq set", {31'h0, irq_q}, {31'h0, |(m & DEFN)});
            u_host.wr(`RX_CLR_OFF, m);
            rchk("latch cleared", `RX_LATCH_OFF, `RX_ZERO);
            chk("irq cleared", {31'h0, irq_q}, 32'h0);
            @(posedge sys_clk) cond_lvl <= `RX_ZERO;
            repeat (3) @(posedge sys_clk);
            u_host.wr(`RX_STAT_OFF, `RX_ZERO);
            rchk("status low", `RX_STAT_OFF, `RX_ZERO);
            rchk("no fall event", `RX_LATCH_OFF, `RX_ZERO);
        end
    endtask

    task automatic masking();
        u_host.wr(`RX_EN_OFF, `RX_ZERO);
        rchk("enable fixed", `RX_EN_OFF, `RX_EN_FIXED);
        @(posedge sys_clk) cond_lvl <= `RX_M_OVER_CUR;
        repeat (3) @(posedge sys_clk);
        rchk("masked latch", `RX_LATCH_OFF, `RX_M_OVER_CUR);
        chk("irq masked", {31'h0, irq_q}, 32'h0);
        @(posedge sys_clk) cond_lvl <= `RX_M_OVER_CUR | `RX_M_RENEG_FAIL;
        repeat (3) @(posedge sys_clk);
        chk("irq fixed enable", {31'h0, irq_q}, 32'h1);
        u_host.wr(`RX_CLR_OFF, `RX_M_RENEG_FAIL);
        u_host.wr(`RX_EN_OFF, DEFN);
        // Enable lands at the write edge, irq one edge later
        repeat (2) @(posedge sys_clk);
        chk("irq enabled", {31'h0, irq_q}, 32'h1);
        u_host.wr(`RX_CLR_OFF, `RX_M_OVER_CUR);
        @(posedge sys_clk) cond_lvl <= `RX_ZERO;
    endtask

    // Only bit 25 takes host writes in either word
    task automatic host_bit25();
        u_host.wr(`RX_LATCH_OFF, 32'hFFFF_FFFF);
        rchk("latch write", `RX_LATCH_OFF, `RX_M_NO_HOST_TMO);
        u_host.wr(`RX_LATCH_OFF, `RX_ZERO);
        rchk("latch write zero", `RX_LATCH_OFF, `RX_ZERO);
        u_host.wr(`RX_STAT_OFF, 32'hFFFF_FFFF);
        rchk("status write", `RX_STAT_OFF, `RX_M_NO_HOST_TMO);
        u_host.wr(`RX_STAT_OFF, `RX_ZERO);
        rchk("status write zero", `RX_STAT_OFF, `RX_ZERO);
    endtask

    initial begin
        #400000;
        bad_count++;
        complete_run();
    end

    initial begin
        arst_n = 1'b0;
        cond_lvl = `RX_ZERO;
        bad_count = 0;
        tests_run = 0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        check_reset();
        sweep();
        masking();
        host_bit25();
        complete_run();
    end
endmodule
`default_nettype wire
